// ---- rtl/wmd_defs.vh ----
// constants for the word move decoder
// How it works
// - opcode 1011 0111 1 B 1 plus 13-bit address stores first_work_reg there
// - size bit of that form: 0 means word transfer, 1 means byte transfer
// - working register zero is the implied source for that store
// - prefix 1000 0, 15-bit word address, dddd loads register from memory
// - prefix 1000 1, 15-bit word address, ssss stores register to memory
// - direct word forms build byte address as encoded bits shifted left, bit 0 zero
// - direct word forms reach every even address from 0 to 65534
// - direct file-register forms with a 15-bit word address are word transfers only
// - 1011 0011 1100 kkkk kkkk dddd writes literal to low byte only
// - opcode 0010 carries 16-bit literal replacing the whole register
// - the 16 literal bits are stored unchanged, signed or unsigned alike
// - low four bits pick destination register for loads and literals
// - low four bits pick source register for the register store
// - no status flag changes for any of these forms
// - each form completes in one cycle; slow peripheral reads may stretch it
`ifndef WMD_DEFS_VH
`define WMD_DEFS_VH
`define WMD_OP_W0F_HI 9'h16F
`define WMD_OP_FW_HI 5'h10
`define WMD_OP_WF_HI 5'h11
`define WMD_OP_LB_HI 12'hB3C
`define WMD_OP_LW_HI 4'h2
`define WMD_FIRST_IDX 4'h0
`define WMD_WORD 16
`define WMD_NREGS 16
`endif

// ---- rtl/wmd_reg_array.v ----
// sixteen-entry working register array with byte lane writes
`timescale 1ns/100ps
`include "wmd_defs.vh"
module wmd_reg_array (
    input wire core_clk,
    input wire sys_rst,
    input wire wr_lo,
    input wire wr_hi,
    input wire [3:0] wr_idx,
    input wire [15:0] wr_data,
    input wire [3:0] rd_idx,
    output wire [15:0] rd_data,
    output wire [15:0] first_data
);
    reg [15:0] regs_reg [0:`WMD_NREGS-1];
    genvar i;
    generate
        for (i = 0; i < `WMD_NREGS; i = i + 1) begin : g_reg
            always @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    regs_reg[i] <= 16'h0000;
                end else if (wr_idx == i) begin
                    if (wr_lo) begin
                        regs_reg[i][7:0] <= wr_data[7:0];
                    end
                    // upper byte kept on byte literal loads
                    if (wr_hi) begin
                        regs_reg[i][15:8] <= wr_data[15:8];
                    end
                end
            end
        end
    endgenerate
    assign rd_data = regs_reg[rd_idx];
    assign first_data = regs_reg[`WMD_FIRST_IDX];
endmodule // wmd_reg_array

// ---- rtl/wmd_word_move_decoder.v ----
// decode and execute of the word and literal move forms
`timescale 1ns/100ps
`include "wmd_defs.vh"
module wmd_word_move_decoder (
    input wire core_clk,
    input wire sys_rst,
    input wire instr_valid,
    input wire [23:0] instr_word,
    input wire mem_ready,
    input wire [15:0] mem_rdata,
    output reg instr_done,
    output reg instr_illegal,
    output reg mem_rd,
    output reg mem_wr,
    output reg [15:0] mem_addr,
    output reg [1:0] mem_be,
    output reg [15:0] mem_wdata,
    output reg [15:0] reg_observe,
    output reg status_write
);
    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;
    // one code per decoded form
    localparam FM_NONE = 3'b000;
    localparam FM_LB = 3'b001;
    localparam FM_LW = 3'b010;
    localparam FM_FW = 3'b011;
    localparam FM_WF = 3'b100;
    localparam FM_W0F = 3'b101;

    reg state_reg;
    reg state_next;
    reg [3:0] load_idx_reg;
    reg [2:0] form;
    wire [3:0] reg_fld = instr_word[3:0];
    wire [15:0] rd_data;
    wire [15:0] first_data;
    // new requests wait while a slow read is pending
    wire take = instr_valid && (state_reg == ST_IDLE);

    wire is_w0f = instr_word[23:15] == `WMD_OP_W0F_HI && instr_word[13];
    wire is_fw = instr_word[23:19] == `WMD_OP_FW_HI;
    wire is_wf = instr_word[23:19] == `WMD_OP_WF_HI;
    wire is_lb = instr_word[23:12] == `WMD_OP_LB_HI;
    wire is_lw = instr_word[23:20] == `WMD_OP_LW_HI;
    wire byte_mode = instr_word[14];
    wire [12:0] faddr13 = instr_word[12:0];
    wire [15:0] waddr = {instr_word[18:4], 1'b0};

    // priority: byte literal, word literal, load, stores
    always @* begin
        form = FM_NONE;
        if (is_lb) begin
            form = FM_LB;
        end else if (is_lw) begin
            form = FM_LW;
        end else if (is_fw) begin
            form = FM_FW;
        end else if (is_wf) begin
            form = FM_WF;
        end else if (is_w0f) begin
            form = FM_W0F;
        end
    end

    reg wr_lo;
    reg wr_hi;
    reg [3:0] wr_idx;
    reg [15:0] wr_data;

    wmd_reg_array u_regs (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wr_lo(wr_lo),
        .wr_hi(wr_hi),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .rd_idx(reg_fld),
        .rd_data(rd_data),
        .first_data(first_data)
    );

    always @* begin
        wr_lo = 1'b0;
        wr_hi = 1'b0;
        wr_idx = reg_fld;
        wr_data = 16'h0000;
        state_next = state_reg;
        case (state_reg)
            ST_WAIT: begin
                if (mem_ready) begin
                    wr_lo = 1'b1;
                    wr_hi = 1'b1;
                    wr_idx = load_idx_reg;
                    wr_data = mem_rdata;
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (instr_valid) begin
                    case (form)
                        FM_LB: begin
                            wr_lo = 1'b1;
                            wr_data = {8'h00, instr_word[11:4]};
                        end
                        FM_LW: begin
                            wr_lo = 1'b1;
                            wr_hi = 1'b1;
                            wr_data = instr_word[19:4];
                        end
                        FM_FW: begin
                            if (mem_ready) begin
                                wr_lo = 1'b1;
                                wr_hi = 1'b1;
                                wr_data = mem_rdata;
                            end else begin
                                state_next = ST_WAIT;
                            end
                        end
                        default: begin
                            wr_lo = 1'b0;
                        end
                    endcase
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // state and pending load destination
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            load_idx_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            if (take && form == FM_FW) begin
                load_idx_reg <= reg_fld;
            end
        end
    end

    // completion, refusal and slow read flags
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            instr_done <= 1'b0;
            instr_illegal <= 1'b0;
            mem_rd <= 1'b0;
        end else begin
            instr_done <= 1'b0;
            instr_illegal <= 1'b0;
            if (state_reg == ST_WAIT) begin
                if (mem_ready) begin
                    mem_rd <= 1'b0;
                    instr_done <= 1'b1;
                end
            end else if (instr_valid) begin
                if (form == FM_NONE) begin
                    instr_illegal <= 1'b1;
                end else if (form == FM_FW && !mem_ready) begin
                    // slow read holds done back until ready
                    mem_rd <= 1'b1;
                end else begin
                    instr_done <= 1'b1;
                end
            end
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_write <= 1'b0;
        end else begin
            status_write <= 1'b0;
        end
    end

    // address, lanes and data hold until the next access
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_wr <= 1'b0;
            mem_addr <= 16'h0000;
            mem_be <= 2'b00;
            mem_wdata <= 16'h0000;
        end else begin
            mem_wr <= 1'b0;
            if (take) begin
                case (form)
                    FM_W0F: begin
                        mem_wr <= 1'b1;
                        if (byte_mode) begin
                            mem_addr <= {3'b000, faddr13};
                            mem_be <= faddr13[0] ? 2'b10 : 2'b01;
                            mem_wdata <= {first_data[7:0], first_data[7:0]};
                        end else begin
                            mem_addr <= {3'b000, faddr13[12:1], 1'b0};
                            mem_be <= 2'b11;
                            mem_wdata <= first_data;
                        end
                    end
                    FM_WF: begin
                        mem_wr <= 1'b1;
                        mem_addr <= waddr;
                        mem_be <= 2'b11;
                        mem_wdata <= rd_data;
                    end
                    FM_FW: begin
                        mem_addr <= waddr;
                        mem_be <= 2'b11;
                    end
                    default: begin
                        mem_wr <= 1'b0;
                    end
                endcase
            end
        end
    end

    // copy of the register named last cycle
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_observe <= 16'h0000;
        end else begin
            reg_observe <= rd_data;
        end
    end
endmodule // wmd_word_move_decoder

// ---- tb/wmd_word_move_decoder_tb.sv ----
// self-checking bench for the word move decoder
`timescale 1ns/100ps
module wmd_word_move_decoder_tb;
    reg clk = 1'h0, rst = 1'h1, vld = 1'h0, rdy = 1'h1;
    reg [23:0] iw = 24'h0;
    wire [15:0] rdat = {iw[18:4], 1'h0} ^ 16'hA5C3;
    wire done, ill, rd, wr, sw;
    wire [15:0] addr, wdat, obs;
    wire [1:0] be;
    int n_mismatch = 0, checked = 0;
    always #50 clk = ~clk;
    wmd_word_move_decoder dut_u (.core_clk(clk), .sys_rst(rst), .instr_valid(vld),
        .instr_word(iw), .mem_ready(rdy), .mem_rdata(rdat), .instr_done(done),
        .instr_illegal(ill), .mem_rd(rd), .mem_wr(wr), .mem_addr(addr), .mem_be(be),
        .mem_wdata(wdat), .reg_observe(obs), .status_write(sw));
    task chk(input [33:0] g, input [33:0] x);
        checked++;
        n_mismatch += (g !== x);
        if (g !== x) $display("[ERR] %0t got %h want %h", $time, g, x);
    endtask
    task run(input [23:0] c, input [3:0] x);
        @(posedge clk) {vld, iw} <= {1'h1, c};
        @(posedge clk) vld <= 1'h0;
        #1 chk({30'h0, wr, ill, done, sw}, {30'h0, x});
    endtask
    task peek(input [3:0] n, input [15:0] x);
        @(posedge clk) iw <= {20'h0, n};
        @(posedge clk) #1 chk({18'h0, obs}, {18'h0, x});
    endtask
    task t_lits;
        run(24'h24231D, 4'h2);
        run(24'hB3C17D, 4'h2);
        peek(4'hD, 16'h4217);
    endtask
    task t_stores;
        run(24'h298F30, 4'h2);
        run(24'hB7A801, 4'hA);
        chk({be, addr, wdat}, {2'h3, 32'h080098F3});
        run(24'hB7E801, 4'hA);
        chk({be, addr, wdat}, {2'h2, 32'h0801F3F3});
        run(24'hB7E800, 4'hA);
        chk({be, addr, wdat}, {2'h1, 32'h0800F3F3});
        run(24'h212347, 4'h2);
        run(24'h8FFFF7, 4'hA);
        chk({be, addr, wdat}, {2'h3, 32'hFFFE1234});
    endtask
    task t_illegal;
        run(24'h9FFFF7, 4'h4);
        chk({be, addr, wdat}, {2'h3, 32'hFFFE1234});
        peek(4'h7, 16'h1234);
    endtask
    task t_reset;
        @(posedge clk) rst <= 1'h1;
        @(posedge clk) rst <= 1'h0;
        #1 chk({27'h0, done, ill, rd, wr, sw, be}, 34'h0);
        chk({2'h0, addr, wdat}, 34'h0);
        peek(4'h7, 16'h0000);
        run(24'h24231D, 4'h2);
        peek(4'hD, 16'h4231);
    endtask
    task t_loads;
        run(24'h813FF3, 4'h2);
        chk({16'h0, be, addr}, {16'h0, 2'h3, 16'h27FE});
        peek(4'h3, 16'h823D);
        @(posedge clk) {rdy, vld, iw} <= {2'h1, 24'h800012};
        @(posedge clk) vld <= 1'h0;
        #1 chk({33'h0, rd}, 34'h1);
        @(posedge clk) rdy <= 1'h1;
        repeat (3) if (done !== 1'h1) @(posedge clk) #1;
        chk({33'h0, done}, 34'h1);
        peek(4'h2, 16'hA5C1);
    endtask
    task close_out;
        $display("%0d checks %0d errors", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        t_lits;
        t_stores;
        t_illegal;
        t_loads;
        t_reset;
        close_out;
    end
    initial begin
        #20000 n_mismatch++;
        close_out;
    end
endmodule // wmd_word_move_decoder_tb

// ---- tb/wmd_word_move_props.sv ----
// assertion checker for the word move decoder
`timescale 1ns/100ps
module wmd_word_move_props (
    input wire core_clk,
    input wire sys_rst,
    input wire instr_valid,
    input wire [23:0] instr_word,
    input wire mem_ready,
    input wire instr_done,
    input wire mem_rd,
    input wire mem_wr,
    input wire [15:0] mem_addr,
    input wire [1:0] mem_be,
    input wire status_write
);
    wire go = instr_valid && !mem_rd;
    wire [23:0] w = instr_word;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_flags_kept: assert property (!status_write) else $error("flag write");
    a_lit_done: assert property (go && w[23:20] == 4'h2 |=> instr_done) else $error("lit");
    a_word_store: assert property (go && w[23:13] == 11'h5BD |=> mem_wr
        && mem_be == 2'h3 && mem_addr == {3'h0, $past(w[12:1]), 1'h0}) else $error("word");
    a_byte_store: assert property (go && w[23:13] == 11'h5BF |=> mem_wr
        && mem_addr == {3'h0, $past(w[12:0])} && mem_be == {$past(w[0]), !$past(w[0])})
        else $error("byte store");
    a_file_store: assert property (go && w[23:19] == 5'h11 |=> mem_wr
        && mem_be == 2'h3 && mem_addr == {$past(w[18:4]), 1'h0}) else $error("file");
    a_fast_load: assert property (go && w[23:19] == 5'h10 && mem_ready
        |=> instr_done && !mem_wr && !mem_rd) else $error("fast load");
    a_slow_load: assert property (go && w[23:19] == 5'h10 && !mem_ready
        |=> mem_rd && !instr_done) else $error("slow load");
    // done may trail the ready edge by one register stage
    a_wait_end: assert property (mem_rd && mem_ready
        |-> ##[1:2] instr_done) else $error("wait");
endmodule // wmd_word_move_props
bind wmd_word_move_decoder wmd_word_move_props u_props (.core_clk, .sys_rst, .instr_valid,
    .instr_word, .mem_ready, .instr_done, .mem_rd, .mem_wr, .mem_addr, .mem_be, .status_write);
